// file: pkg/rtdr_pkg.sv
// constants and carrier types for the remote diode temperature result block
package rtdr_pkg;
    localparam int ADC_W = 12;
    localparam int RAW_W = 15;
    localparam int RES_W = 10;
    localparam int AVG_N = 16;
    localparam int AVG_LOG2 = 4;
    localparam int OFS_W = 8;
    localparam int ADDR_W = 12;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_REMOTE1 = 8'h25;
    localparam logic [7:0] IDX_REMOTE2 = 8'h27;
    localparam logic [7:0] IDX_OFS1 = 8'h70;
    localparam logic [7:0] IDX_OFS2 = 8'h72;
    localparam logic [7:0] IDX_CFG2 = 8'h73;
    localparam logic [7:0] IDX_FRAC = 8'h77;
    localparam logic [7:0] IDX_CFG5 = 8'h7C;
    localparam logic [7:0] IDX_STATUS = 8'h7E;
    // field positions
    localparam int CFG2_AVG_OFF_BIT = 4;
    localparam int CFG5_TWOS_BIT = 1;
    localparam int FRAC_R1_LSB = 2;
    localparam int FRAC_R2_LSB = 6;
    localparam int STAT_FROZEN_BIT = 2;
    // reset values
    localparam logic [7:0] CFG2_RST = 8'h00;
    localparam logic [7:0] CFG5_RST = 8'h00;
    localparam logic [7:0] OFS_RST = 8'h00;
    localparam logic [RES_W-1:0] RES_RST = 10'h000;
    // result coding, quarter degrees; extended code 0 means -64 C
    localparam logic [RES_W-1:0] FAULT_TWOS = 10'h200;
    localparam logic [RES_W-1:0] FAULT_EXT = 10'h000;
    localparam logic signed [16:0] EXT_BIAS = 17'sd256;
    localparam logic signed [16:0] EXT_MIN = 17'sd4;
    localparam logic signed [16:0] EXT_MAX = 17'sd1023;
    localparam logic signed [16:0] TWOS_MIN = -17'sd252;
    localparam logic signed [16:0] TWOS_MAX = 17'sd511;

    typedef enum logic [1:0] {
        BIAS_BASE = 2'b00,
        BIAS_MULT1 = 2'b01,
        BIAS_MULT2 = 2'b10
    } rtdr_bias_t;

    typedef enum logic [2:0] {
        SEQ_BASE1 = 3'b000,
        SEQ_MULT1 = 3'b001,
        SEQ_BASE2 = 3'b010,
        SEQ_MULT2 = 3'b011,
        SEQ_DONE = 3'b100
    } rtdr_seq_t;

    // one finished measurement cycle for a channel
    typedef struct packed {
        logic valid;
        logic fault;
        logic signed [RAW_W-1:0] raw;
    } rtdr_meas_t;

    typedef struct packed {
        logic avg_off;
        logic twos;
    } rtdr_cfg_t;
endpackage

// file: hw/rtdr_chan.sv
// per-channel averaging, offset correction and result coding
`timescale 1ns/1ps
`default_nettype none
module rtdr_chan #(
    parameter int AVG_N = rtdr_pkg::AVG_N
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire rtdr_pkg::rtdr_meas_t meas,
    input wire rtdr_pkg::rtdr_cfg_t cfg,
    input wire logic [rtdr_pkg::OFS_W-1:0] offset,
    output logic res_valid_q,
    output logic [rtdr_pkg::RES_W-1:0] res_q,
    output logic fault_q
);
    logic signed [18:0] acc_q;
    logic [3:0] cnt_q;
    logic signed [18:0] sum_w;
    logic signed [16:0] q_w;
    logic signed [16:0] t_w;
    logic [rtdr_pkg::RES_W-1:0] enc_w;
    logic last_w;

    // average, then offset in 0.5 C steps (two quarter steps), then clamp
    always_comb begin
        sum_w = acc_q + 19'(meas.raw);
        last_w = cfg.avg_off || (cnt_q == 4'(AVG_N - 1));
        if (cfg.avg_off) begin
            q_w = 17'(meas.raw);
        end else begin
            q_w = 17'(sum_w >>> rtdr_pkg::AVG_LOG2);
        end
        q_w = q_w + 17'({{9{offset[7]}}, offset} <<< 1);
        t_w = q_w - rtdr_pkg::EXT_BIAS;
        if (cfg.twos) begin
            if (t_w < rtdr_pkg::TWOS_MIN) t_w = rtdr_pkg::TWOS_MIN;
            else if (t_w > rtdr_pkg::TWOS_MAX) t_w = rtdr_pkg::TWOS_MAX;
            enc_w = t_w[rtdr_pkg::RES_W-1:0];
        end else begin
            // offset 64 coding, zero kept for fault
            if (q_w < rtdr_pkg::EXT_MIN) q_w = rtdr_pkg::EXT_MIN;
            else if (q_w > rtdr_pkg::EXT_MAX) q_w = rtdr_pkg::EXT_MAX;
            enc_w = q_w[rtdr_pkg::RES_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= '0;
            cnt_q <= '0;
        end else if (meas.valid) begin
            if (meas.fault || last_w) begin
                acc_q <= '0;
                cnt_q <= '0;
            end else begin
                acc_q <= sum_w;
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_valid_q <= 1'b0;
            res_q <= rtdr_pkg::RES_RST;
            fault_q <= 1'b0;
        end else begin
            res_valid_q <= meas.valid && (meas.fault || last_w);
            if (meas.valid && meas.fault) begin
                res_q <= cfg.twos ? rtdr_pkg::FAULT_TWOS : rtdr_pkg::FAULT_EXT;
                fault_q <= 1'b1;
            end else if (meas.valid && last_w) begin
                res_q <= enc_w;
                fault_q <= 1'b0;
            end
        end
    end

    // helper: valid measurements since the last result
    logic [4:0] seen_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) seen_q <= '0;
        else if (res_valid_q) seen_q <= 5'(meas.valid);
        else if (meas.valid) seen_q <= seen_q + 5'h1;
    end

    avg_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        res_valid_q && !fault_q && !cfg.avg_off && !$past(cfg.avg_off) |-> seen_q == 5'd16)
        else $error("averaged result without sixteen measurements");
    single_meas_a: assert property (@(posedge pclk) disable iff (!presetn)
        meas.valid && cfg.avg_off |=> res_valid_q)
        else $error("averaging off did not report the single measurement");
    fault_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        meas.valid && meas.fault |=> fault_q && res_q == ($past(cfg.twos) ? 10'h200 : 10'h000))
        else $error("fault code missing");
    ext_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        res_valid_q && !fault_q && !$past(cfg.twos) |-> res_q[9:2] != 8'h00)
        else $error("extended result collides with fault code");
    twos_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        res_valid_q && !fault_q && $past(cfg.twos) |-> $signed(res_q) >= -10'sd252)
        else $error("twos result below -63 C");
    offset_add_a: assert property (@(posedge pclk) disable iff (!presetn)
        meas.valid && !meas.fault && cfg.avg_off && !cfg.twos && meas.raw > 15'sd300 && meas.raw < 15'sd700
        |=> $signed({1'b0, res_q}) == $past(meas.raw) + 2 * $signed($past(offset)))
        else $error("offset not applied");
    fault_cov_c: cover property (@(posedge pclk) disable iff (!presetn) res_valid_q && fault_q);
    twos_cov_c: cover property (@(posedge pclk) disable iff (!presetn) res_valid_q && cfg.twos && !fault_q);
endmodule
`default_nettype wire

// file: hw/rtdr_top.sv
// remote diode temperature result block: bias sequencer, two channels, APB registers
// Overview of operation
// - each cycle biases base then first multiple, base then second multiple.
// - each result averages sixteen consecutive measurement cycles, or takes a single one when averaging is off.
// - results are 10-bit, 0.25 C per step, twos complement in standard format.
// - upper eight bits in value register, two fraction bits in shared register.
// - twos format: -63 C is C1, 127 C is 7F, fault is 80 with zero fraction.
// - extended format adds 64; zero upper byte means diode fault.
// - channel offset register is added as signed correction to every result except the fault code.
// - two remote channels, each with its own value register.
// - configuration bit selects clamped twos format, else extended range.
// - reading the fraction register freezes value registers until all are read.
// - offset registers hold 8-bit twos complement in 0.5 C steps.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rtdr_top #(
    parameter logic signed [rtdr_pkg::RAW_W-1:0] TEMP_ZERO = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rtdr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [1:0] bias_sel,
    output logic chan_sel,
    output logic adc_start,
    input wire logic adc_done,
    input wire logic [rtdr_pkg::ADC_W-1:0] adc_data,
    input wire logic [1:0] sensor_fault_async
);
    rtdr_pkg::rtdr_seq_t seq_q;
    logic chan_q;
    logic wait_q;
    logic start_q;
    logic [rtdr_pkg::ADC_W-1:0] smp_q [4];
    logic signed [rtdr_pkg::RAW_W-1:0] raw_w;
    rtdr_pkg::rtdr_meas_t meas_w [2];
    rtdr_pkg::rtdr_cfg_t cfg_w;
    logic [7:0] cfg2_q;
    logic [7:0] cfg5_q;
    logic [7:0] ofs_q [2];
    logic [rtdr_pkg::RES_W-1:0] shown_q [2];
    logic [rtdr_pkg::RES_W-1:0] res_w [2];
    logic res_valid_w [2];
    logic fault_w [2];
    logic frozen_q;
    logic [1:0] read_q;
    logic [1:0] flt_s1_q, flt_s2_q, flt_s3_q, flt_q;
    logic setup_w, access_w, mapped_w, frac_rd_w;
    logic [7:0] idx_w;
    logic [31:0] rd_w;

    // fault pins are asynchronous: three stages, change taken when stages 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flt_s1_q <= '0;
            flt_s2_q <= '0;
            flt_s3_q <= '0;
            flt_q <= '0;
        end else begin
            flt_s1_q <= sensor_fault_async;
            flt_s2_q <= flt_s1_q;
            flt_s3_q <= flt_s2_q;
            for (int i = 0; i < 2; i++) begin
                if (flt_s2_q[i] == flt_s3_q[i]) flt_q[i] <= flt_s3_q[i];
            end
        end
    end

    // bias sequence, one conversion per bias step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q <= rtdr_pkg::SEQ_BASE1;
            wait_q <= 1'b0;
            start_q <= 1'b0;
            chan_q <= 1'b0;
        end else begin
            start_q <= 1'b0;
            case (seq_q)
                rtdr_pkg::SEQ_DONE: begin
                    chan_q <= ~chan_q;
                    seq_q <= rtdr_pkg::SEQ_BASE1;
                end
                default: begin
                    if (!wait_q) begin
                        start_q <= 1'b1;
                        wait_q <= 1'b1;
                    end else if (adc_done && !start_q) begin
                        wait_q <= 1'b0;
                        seq_q <= rtdr_rtdr_next(seq_q);
                    end
                end
            endcase
        end
    end

    function automatic rtdr_pkg::rtdr_seq_t rtdr_rtdr_next(input rtdr_pkg::rtdr_seq_t s);
        case (s)
            rtdr_pkg::SEQ_BASE1: rtdr_rtdr_next = rtdr_pkg::SEQ_MULT1;
            rtdr_pkg::SEQ_MULT1: rtdr_rtdr_next = rtdr_pkg::SEQ_BASE2;
            rtdr_pkg::SEQ_BASE2: rtdr_rtdr_next = rtdr_pkg::SEQ_MULT2;
            default: rtdr_rtdr_next = rtdr_pkg::SEQ_DONE;
        endcase
    endfunction

    // conversion results kept per bias step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 4; i++) smp_q[i] <= '0;
        end else if (wait_q && adc_done && !start_q && seq_q != rtdr_pkg::SEQ_DONE) begin
            smp_q[seq_q[1:0]] <= adc_data;
        end
    end

    always_comb begin
        case (seq_q)
            rtdr_pkg::SEQ_MULT1: bias_sel = rtdr_pkg::BIAS_MULT1;
            rtdr_pkg::SEQ_MULT2: bias_sel = rtdr_pkg::BIAS_MULT2;
            default: bias_sel = rtdr_pkg::BIAS_BASE;
        endcase
    end
    assign adc_start = start_q;
    assign chan_sel = chan_q;

    // two deltas combined; the second cancels series resistance
    assign raw_w = 15'(2 * ($signed({3'b000, smp_q[1]}) - $signed({3'b000, smp_q[0]})))
        - 15'($signed({3'b000, smp_q[3]}) - $signed({3'b000, smp_q[2]})) - TEMP_ZERO;
    assign cfg_w.avg_off = cfg2_q[rtdr_pkg::CFG2_AVG_OFF_BIT];
    assign cfg_w.twos = cfg5_q[rtdr_pkg::CFG5_TWOS_BIT];

    // one averaging and coding unit per channel
    for (genvar c = 0; c < 2; c++) begin : g_chan
        assign meas_w[c].valid = (seq_q == rtdr_pkg::SEQ_DONE) && (chan_q == 1'(c));
        assign meas_w[c].fault = flt_q[c];
        assign meas_w[c].raw = raw_w;
        rtdr_chan #(.AVG_N(rtdr_pkg::AVG_N)) u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .meas(meas_w[c]),
            .cfg(cfg_w),
            .offset(ofs_q[c]),
            .res_valid_q(res_valid_w[c]),
            .res_q(res_w[c]),
            .fault_q(fault_w[c])
        );
    end

    // APB decode; zero wait states, read data sampled in the setup cycle, write data in the access cycle
    assign setup_w = psel && !penable;
    assign access_w = psel && penable;
    assign idx_w = paddr[9:2];
    assign pready = 1'b1;
    always_comb begin
        mapped_w = 1'b1;
        rd_w = 32'h0000_0000;
        if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) mapped_w = 1'b0;
        else if (idx_w == rtdr_pkg::IDX_REMOTE1) rd_w[7:0] = shown_q[0][9:2];
        else if (idx_w == rtdr_pkg::IDX_REMOTE2) rd_w[7:0] = shown_q[1][9:2];
        else if (idx_w == rtdr_pkg::IDX_FRAC) begin
            // fraction bits of both channels side by side
            rd_w[rtdr_pkg::FRAC_R1_LSB +: 2] = shown_q[0][1:0];
            rd_w[rtdr_pkg::FRAC_R2_LSB +: 2] = shown_q[1][1:0];
        end
        else if (idx_w == rtdr_pkg::IDX_OFS1) rd_w[7:0] = ofs_q[0];
        else if (idx_w == rtdr_pkg::IDX_OFS2) rd_w[7:0] = ofs_q[1];
        else if (idx_w == rtdr_pkg::IDX_CFG2) rd_w[7:0] = cfg2_q;
        else if (idx_w == rtdr_pkg::IDX_CFG5) rd_w[7:0] = cfg5_q;
        else if (idx_w == rtdr_pkg::IDX_STATUS) begin
            rd_w[1:0] = {fault_w[1], fault_w[0]};
            rd_w[rtdr_pkg::STAT_FROZEN_BIT] = frozen_q;
        end
        else mapped_w = 1'b0;
    end
    assign pslverr = access_w && !mapped_w;
    assign frac_rd_w = setup_w && !pwrite && mapped_w && idx_w == rtdr_pkg::IDX_FRAC;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= '0;
        else if (setup_w && !pwrite) prdata <= rd_w;
    end

    // offsets and configuration written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ofs_q[0] <= rtdr_pkg::OFS_RST;
            ofs_q[1] <= rtdr_pkg::OFS_RST;
            cfg2_q <= rtdr_pkg::CFG2_RST;
            cfg5_q <= rtdr_pkg::CFG5_RST;
        end else if (access_w && pwrite && mapped_w) begin
            if (idx_w == rtdr_pkg::IDX_OFS1) ofs_q[0] <= pwdata[7:0];
            else if (idx_w == rtdr_pkg::IDX_OFS2) ofs_q[1] <= pwdata[7:0];
            else if (idx_w == rtdr_pkg::IDX_CFG2) cfg2_q <= pwdata[7:0];
            else if (idx_w == rtdr_pkg::IDX_CFG5) cfg5_q <= pwdata[7:0];
        end
    end

    // freeze on fraction read, release once both value registers are read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frozen_q <= 1'b0;
            read_q <= '0;
        end else if (frac_rd_w) begin
            frozen_q <= 1'b1;
            read_q <= '0;
        end else if (frozen_q && setup_w && !pwrite && mapped_w) begin
            if (read_q[1] && idx_w == rtdr_pkg::IDX_REMOTE1) frozen_q <= 1'b0;
            else if (read_q[0] && idx_w == rtdr_pkg::IDX_REMOTE2) frozen_q <= 1'b0;
            if (idx_w == rtdr_pkg::IDX_REMOTE1) read_q[0] <= 1'b1;
            if (idx_w == rtdr_pkg::IDX_REMOTE2) read_q[1] <= 1'b1;
        end
    end

    // value registers follow results unless frozen; release picks up latest
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shown_q[0] <= rtdr_pkg::RES_RST;
            shown_q[1] <= rtdr_pkg::RES_RST;
        end else if (!frozen_q && !frac_rd_w) begin
            shown_q[0] <= res_w[0];
            shown_q[1] <= res_w[1];
        end
    end

    bias_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        seq_q == rtdr_pkg::SEQ_DONE |-> $past(bias_sel) == rtdr_pkg::BIAS_MULT2)
        else $error("measurement ended without second multiple");
    start_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        adc_start |=> !adc_start)
        else $error("conversion start longer than one cycle");
    freeze_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        frozen_q ##1 frozen_q |-> $stable(shown_q[0]) && $stable(shown_q[1]))
        else $error("value register changed while frozen");
    frac_coherent_a: assert property (@(posedge pclk) disable iff (!presetn)
        frac_rd_w |=> prdata[3:2] == shown_q[0][1:0] && prdata[7:6] == shown_q[1][1:0])
        else $error("fraction read does not match held values");
    freeze_cov_c: cover property (@(posedge pclk) disable iff (!presetn) frozen_q ##1 !frozen_q);
endmodule
`default_nettype wire

// file: verification/rtdr_diode_model.sv
// behavioural remote diode plus converter answering the bias sequencer
`timescale 1ns/1ps
`default_nettype none
module rtdr_diode_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] bias_sel,
    input wire logic chan_sel,
    input wire logic adc_start,
    input wire logic [10:0] temp1,
    input wire logic [10:0] temp2,
    output logic adc_done,
    output logic [11:0] adc_data,
    output int meas_cnt
);
    int wait_q;
    int q;
    int v;
    logic slow_q;
    logic ch_q;
    logic [1:0] bias_q;
    logic [1:0] dith_q;
    // one conversion in flight; latency alternates between quick and slow
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 0;
            slow_q <= 1'b0;
            adc_done <= 1'b0;
            adc_data <= 12'hA5A;
            dith_q <= 2'b00;
            meas_cnt <= 0;
        end else if (adc_start) begin
            bias_q <= bias_sel;
            ch_q <= chan_sel;
            slow_q <= !slow_q;
            wait_q <= slow_q ? 6 : 1;
            adc_done <= 1'b0;
        end else if (wait_q == 1) begin
            // base, first and second multiple; only 2*d1-d2 gives the temperature
            q = (ch_q ? int'(temp2) : int'(temp1)) + (dith_q[ch_q] ? 4 : -4);
            v = (bias_q == 2'b01) ? 150 + q : (bias_q == 2'b10) ? 200 + q : 100;
            adc_data <= v[11:0];
            adc_done <= 1'b1;
            wait_q <= 0;
            // noise alternates per measurement so only averaging gives the exact value
            if (bias_q == 2'b10) begin
                dith_q[ch_q] <= !dith_q[ch_q];
                meas_cnt <= meas_cnt + 1;
            end
        end else begin
            if (wait_q > 1)
                wait_q <= wait_q - 1;
            adc_done <= 1'b0;
            // idle output toggles so stale data never looks valid
            adc_data <= ~adc_data;
        end
    end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench: apb register tests against the diode model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, adc_start, adc_done, chan_sel, er, twos;
    logic [1:0] bias_sel;
    logic [1:0] flt = 2'b00;
    logic [11:0] adc_data;
    logic [10:0] t1 = 11'h164;
    logic [10:0] t2 = 11'h0D9;
    logic [7:0] ofs1 = 8'h00;
    logic [7:0] ofs2 = 8'h00;
    logic [31:0] rd;
    logic [9:0] e1, e2;
    int err_total = 0;
    int n_compared = 0;
    int meas_cnt;
    always #2.5 pclk = ~pclk;
    rtdr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bias_sel(bias_sel), .chan_sel(chan_sel), .adc_start(adc_start), .adc_done(adc_done),
        .adc_data(adc_data), .sensor_fault_async(flt));
    rtdr_diode_model sensor (.pclk(pclk), .presetn(presetn), .bias_sel(bias_sel), .chan_sel(chan_sel),
        .adc_start(adc_start), .temp1(t1), .temp2(t2), .adc_done(adc_done), .adc_data(adc_data),
        .meas_cnt(meas_cnt));
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // no assumed latency: the wait ends when pready is seen; only the watchdog ends a wait that hangs
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // wait for a number of finished measurement cycles, both channels together
    task automatic settle(input int n);
        int s;
        s = meas_cnt;
        while (meas_cnt < s + n)
            @(posedge pclk);
    endtask
    // expected 10-bit code; offset counts half degrees, code quarter degrees
    function automatic logic [9:0] enc(input int q, input logic [7:0] o, input logic f);
        int v;
        v = q + 2 * int'($signed(o));
        if (f)
            return twos ? rtdr_pkg::FAULT_TWOS : rtdr_pkg::FAULT_EXT;
        if (twos)
            v = (v - 256 < -252) ? -252 : (v - 256 > 511) ? 511 : v - 256;
        else
            v = (v < 4) ? 4 : (v > 1023) ? 1023 : v;
        return v[9:0];
    endfunction
    // fraction first so both value reads stay coherent
    task automatic check_all();
        e1 = enc(int'(t1), ofs1, flt[0]);
        e2 = enc(int'(t2), ofs2, flt[1]);
        apb(1'b0, rtdr_pkg::IDX_FRAC, 8'h00);
        `CHK(rd, {24'h000000, e2[1:0], 2'b00, e1[1:0], 2'b00})
        apb(1'b0, rtdr_pkg::IDX_STATUS, 8'h00);
        `CHK(rd, {29'h00000000, 1'b1, flt})
        apb(1'b0, rtdr_pkg::IDX_REMOTE1, 8'h00);
        `CHK(rd, {24'h000000, e1[9:2]})
        apb(1'b0, rtdr_pkg::IDX_REMOTE2, 8'h00);
        `CHK(rd, {24'h000000, e2[9:2]})
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog, far beyond the expected fourteen thousand cycles
    initial begin
        repeat (80000) @(posedge pclk);
        err_total++;
        conclude();
    end
    initial begin
        twos = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values of writable registers, then an unmapped index
        apb(1'b0, rtdr_pkg::IDX_OFS1, 8'h00);
        `CHK(rd, 32'h00000000)
        apb(1'b0, rtdr_pkg::IDX_CFG5, 8'h00);
        `CHK(rd, 32'h00000000)
        apb(1'b0, 8'h40, 8'h00);
        `CHK({er, rd}, 33'h100000000)
        apb(1'b1, rtdr_pkg::IDX_REMOTE1, 8'hFF);
        settle(70);
        check_all();
        // signed offsets on both channels, one negative
        ofs1 = 8'hF6;
        ofs2 = 8'h03;
        apb(1'b1, rtdr_pkg::IDX_OFS1, ofs1);
        apb(1'b1, rtdr_pkg::IDX_OFS2, ofs2);
        apb(1'b0, rtdr_pkg::IDX_OFS1, 8'h00);
        `CHK(rd, {24'h000000, ofs1})
        settle(70);
        check_all();
        // twos format at both clamp limits
        twos = 1'b1;
        ofs2 = 8'h00;
        t1 <= 11'h3FF;
        t2 <= 11'h000;
        apb(1'b1, rtdr_pkg::IDX_OFS2, ofs2);
        apb(1'b1, rtdr_pkg::IDX_CFG5, 8'h02);
        settle(70);
        check_all();
        // diode fault on channel two in both formats
        flt <= 2'b10;
        settle(70);
        check_all();
        twos = 1'b0;
        apb(1'b1, rtdr_pkg::IDX_CFG5, 8'h00);
        settle(70);
        check_all();
        flt <= 2'b00;
        // channel two in mid range so the offset property is exercised
        t2 <= 11'h190;
        // averaging off shows one noisy measurement
        apb(1'b1, rtdr_pkg::IDX_CFG2, 8'h10);
        settle(10);
        apb(1'b0, rtdr_pkg::IDX_FRAC, 8'h00);
        e1[1:0] = rd[3:2];
        apb(1'b0, rtdr_pkg::IDX_REMOTE1, 8'h00);
        e1[9:2] = rd[7:0];
        apb(1'b0, rtdr_pkg::IDX_REMOTE2, 8'h00);
        `CHK(e1 === enc(int'(t1) + 4, ofs1, 1'b0) || e1 === enc(int'(t1) - 4, ofs1, 1'b0), 1'b1)
        apb(1'b1, rtdr_pkg::IDX_CFG2, 8'h00);
        settle(70);
        // fraction read freezes values across a temperature change
        e1 = enc(int'(t1), ofs1, 1'b0);
        apb(1'b0, rtdr_pkg::IDX_FRAC, 8'h00);
        t1 <= 11'h200;
        settle(70);
        apb(1'b0, rtdr_pkg::IDX_REMOTE1, 8'h00);
        `CHK(rd, {24'h000000, e1[9:2]})
        apb(1'b0, rtdr_pkg::IDX_REMOTE2, 8'h00);
        apb(1'b0, rtdr_pkg::IDX_STATUS, 8'h00);
        `CHK(rd, 32'h00000000)
        check_all();
        conclude();
    end
endmodule
`default_nettype wire
